// file: bench/smc_core_model.sv
// Core and interrupt system model facing the sleep mode controller
`timescale 1ns/1ps
`default_nettype none
module smc_core_model (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic sleep_req, // Bench asks core to run sleep
    input wire logic [8:0] irq_line, // Raw interrupt source levels
    input wire logic core_halt, // Core stalled by controller
    input wire logic irq_take, // Handler entry pulse
    output logic sleep_instr, // Sleep instruction executed
    output logic irq_conv_done, // Converter complete
    output logic irq_wdt, // Watchdog
    output logic irq_twi_match, // Address match
    output logic irq_async_timer, // Async timer
    output logic irq_nvm_ready, // Nonvolatile ready
    output logic irq_ext_level, // External level
    output logic irq_ext_edge, // External edge
    output logic irq_pin_change, // Pin change
    output logic irq_periph // Other peripherals
);
    logic [8:0] acked;
    logic [8:0] irq_out;
    // Halted core executes nothing
    assign sleep_instr = sleep_req & ~core_halt;
    // Handler clears the served source; a level lasts only while held
    assign irq_out = irq_line & ~acked;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acked <= 9'h000;
        end else begin
            acked <= (acked | (irq_take ? irq_out : 9'h000)) & irq_line;
        end
    end
    assign {irq_periph, irq_pin_change, irq_ext_edge, irq_ext_level, irq_nvm_ready,
            irq_async_timer, irq_twi_match, irq_wdt, irq_conv_done} = irq_out;
endmodule // smc_core_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking testbench for the sleep mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import smc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, sleep_allow = 1'b0, sleep_req = 1'b0;
    logic [2:0] sleep_mode_select = 3'h0;
    logic brownout_sleep_off_unlock = 1'b0, brownout_sleep_off_write = 1'b0, brownout_sleep_off_wdata = 1'b0, conv_enabled = 1'b0;
    logic async_timer_async = 1'b0, comparator_power_off = 1'b0, rst_req = 1'b0;
    logic [CNT_W-1:0] reset_timeout = 16'h000A;
    logic [8:0] irq_line = 9'h000;
    logic sleep_instr, i_conv, i_wdt, i_twi, i_atm, i_nvm, i_lvl, i_edge, i_pc, i_per;
    logic cpu_clk_en, flash_clk_en, io_clk_en, conv_clk_en, async_clk_en, main_osc_en;
    logic timer_osc_en, brownout_detector_en, brownout_sleep_off, conv_auto_start;
    logic core_halt, sleeping, irq_take, reset_vector, comparator_en;
    int bad_count = 0, check_count = 0;
    localparam logic [2:0] MODES [6] = '{MODE_IDLE, MODE_NOISE, MODE_PDOWN, MODE_PSAVE,
                                         MODE_STBY, MODE_XSTBY};
    // cpu, flash, io, conv, async, osc with the timer asynchronous
    localparam logic [5:0] CLK_TBL [6] = '{6'h0F, 6'h07, 6'h00, 6'h02, 6'h01, 6'h03};
    always #5 clk = ~clk;
    smc_sleep_ctrl #(.BOD_WAKE(20)) dut (.clk(clk), .rst_n(rst_n), .sleep_allow(sleep_allow),
        .sleep_mode_select(sleep_mode_select), .sleep_instr(sleep_instr),
        .brownout_sleep_off_unlock(brownout_sleep_off_unlock), .brownout_sleep_off_write(brownout_sleep_off_write), .brownout_sleep_off_wdata(brownout_sleep_off_wdata),
        .conv_enabled(conv_enabled), .async_timer_async(async_timer_async),
        .comparator_power_off(comparator_power_off), .reset_timeout(reset_timeout),
        .rst_req(rst_req), .irq_conv_done(i_conv), .irq_wdt(i_wdt), .irq_twi_match(i_twi),
        .irq_async_timer(i_atm), .irq_nvm_ready(i_nvm), .irq_ext_level(i_lvl),
        .irq_ext_edge(i_edge), .irq_pin_change(i_pc), .irq_periph(i_per),
        .cpu_clk_en(cpu_clk_en), .flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en),
        .conv_clk_en(conv_clk_en), .async_clk_en(async_clk_en), .main_osc_en(main_osc_en),
        .timer_osc_en(timer_osc_en), .comparator_en(comparator_en),
        .brownout_detector_en(brownout_detector_en), .brownout_sleep_off(brownout_sleep_off),
        .conv_auto_start(conv_auto_start), .core_halt(core_halt), .sleeping(sleeping),
        .irq_take(irq_take), .reset_vector(reset_vector));
    smc_core_model core (.clk(clk), .rst_n(rst_n), .sleep_req(sleep_req),
        .irq_line(irq_line), .core_halt(core_halt), .irq_take(irq_take),
        .sleep_instr(sleep_instr), .irq_conv_done(i_conv), .irq_wdt(i_wdt),
        .irq_twi_match(i_twi), .irq_async_timer(i_atm), .irq_nvm_ready(i_nvm),
        .irq_ext_level(i_lvl), .irq_ext_edge(i_edge), .irq_pin_change(i_pc),
        .irq_periph(i_per));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic enter(input logic [2:0] m);
        sleep_mode_select = m;
        sleep_req = 1'b1;
        @(negedge clk);
        sleep_req = 1'b0;
    endtask
    task automatic wake_wait(input int exp_k, input string nm);
        int k;
        for (k = 1; k <= 200; k++) begin
            @(negedge clk);
            if (irq_take === 1'b1) begin
                break;
            end
        end
        if (k > 200) begin
            bad_count++;
            conclude();
        end
        check(nm, k, exp_k);
        irq_line = 9'h000;
        @(negedge clk);
    endtask
    task automatic brownout_sleep_off_seq(input logic unl, input int gap, input logic d);
        brownout_sleep_off_unlock = unl;
        if (gap > 0) begin
            @(negedge clk);
            brownout_sleep_off_unlock = 1'b0;
            repeat (gap - 1) @(negedge clk);
        end
        brownout_sleep_off_write = 1'b1;
        brownout_sleep_off_wdata = d;
        @(negedge clk);
        brownout_sleep_off_write = 1'b0;
        brownout_sleep_off_unlock = 1'b0;
        @(negedge clk);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int lost;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check("brownout_sleep_off_reset", brownout_sleep_off, 16'h0000);
        check("clocks_reset", {cpu_clk_en, io_clk_en, main_osc_en, core_halt}, 16'h000E);
        enter(MODE_PDOWN);
        check("no_allow", sleeping, 16'h0000);
        sleep_allow = 1'b1;
        enter(3'h4);
        @(negedge clk);
        enter(3'h5);
        check("reserved", sleeping, 16'h0000);
        $display("Test entry refusal done");
        for (int aa = 0; aa < 2; aa++) begin
            async_timer_async = aa[0];
            comparator_power_off = aa[0];
            for (int i = 0; i < 6; i++) begin
                enter(MODES[i]);
                check("sleep_on", sleeping, 16'h0001);
                check("clocks", {cpu_clk_en, flash_clk_en, io_clk_en, conv_clk_en,
                    async_clk_en, main_osc_en}, (aa != 0 || i == 0) ? CLK_TBL[i] :
                    CLK_TBL[i] & 6'h3D);
                check("timer_osc", timer_osc_en, aa ? CLK_TBL[i][1] : 1'b0);
                check("comparator", comparator_en, (aa == 0 && i < 2) ? 16'h0001 : 16'h0000);
                rst_req = 1'b1;
                @(negedge clk);
                check("rst_wake", {reset_vector, sleeping}, 16'h0002);
                rst_req = 1'b0;
                @(negedge clk);
            end
        end
        $display("Test mode clocks done");
        brownout_sleep_off_seq(1'b0, 0, 1'b1);
        check("brownout_sleep_off_nounlock", brownout_sleep_off, 16'h0000);
        brownout_sleep_off_seq(1'b1, 0, 1'b1);
        check("brownout_sleep_off_samecycle", brownout_sleep_off, 16'h0000);
        brownout_sleep_off_seq(1'b1, 5, 1'b1);
        check("brownout_sleep_off_late", brownout_sleep_off, 16'h0000);
        brownout_sleep_off_seq(1'b1, 4, 1'b1);
        check("brownout_sleep_off_edge", brownout_sleep_off, 16'h0001);
        brownout_sleep_off_seq(1'b1, 1, 1'b0);
        brownout_sleep_off_seq(1'b1, 2, 1'b1);
        check("brownout_sleep_off_rewrite", brownout_sleep_off, 16'h0001);
        $display("Test brownout bit done");
        enter(MODE_IDLE);
        check("bod_idle", brownout_detector_en, 16'h0001);
        irq_line = 9'h040;
        wake_wait(5, "idle_edge_wake");
        enter(MODE_PDOWN);
        check("bod_off", brownout_detector_en, 16'h0000);
        irq_line = 9'h149;
        repeat (30) @(negedge clk);
        check("pdown_ignored", sleeping, 16'h0001);
        irq_line = 9'h080;
        wake_wait(25, "bod_wake_delay");
        check("bod_back", brownout_detector_en, 16'h0001);
        conv_enabled = 1'b1;
        enter(MODE_NOISE);
        check("auto_conv", conv_auto_start, 16'h0001);
        check("bod_noise", brownout_detector_en, 16'h0001);
        irq_line = 9'h140;
        repeat (10) @(negedge clk);
        check("noise_ignored", sleeping, 16'h0001);
        irq_line = 9'h001;
        wake_wait(5, "noise_wake");
        brownout_sleep_off_seq(1'b1, 1, 1'b0);
        enter(MODE_STBY);
        irq_line = 9'h004;
        wake_wait(11, "stby_wake");
        enter(MODE_PDOWN);
        irq_line = 9'h002;
        wake_wait(15, "pdown_wake");
        $display("Test wake timing done");
        enter(MODE_PDOWN);
        irq_line = 9'h020;
        repeat (3) @(negedge clk);
        irq_line = 9'h000;
        lost = 0;
        for (int k = 0; k < 100 && core_halt !== 1'b0; k++) begin
            @(negedge clk);
            if (irq_take === 1'b1) begin
                lost++;
            end
        end
        check("level_woke", {core_halt, sleeping}, 16'h0000);
        check("level_no_irq", lost, 16'h0000);
        $display("Test dropped level done");
        conclude();
    end
endmodule // testbench
`default_nettype wire

// file: pkg/smc_pkg.sv
// Constants for the sleep mode controller
package smc_pkg;
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_NOISE = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STBY = 3'h6;
    localparam logic [2:0] MODE_XSTBY = 3'h7;
    localparam int CNT_W = 16;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BOD_WAKE_NS = 60000;
    localparam int BOD_WAKE_CYCLES = (BOD_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] HALT_CYCLES = 16'h0004;
    localparam logic [CNT_W-1:0] STBY_WAKE_CYCLES = 16'h0006;
    localparam logic [2:0] UNLOCK_WINDOW = 3'h4;
    localparam logic BROWNOUT_SLEEP_OFF_RESET = 1'b0;
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SLEEP = 2'b01,
        ST_START = 2'b10,
        ST_HALT = 2'b11
    } smc_state_type;
endpackage

// file: rtl/smc_sleep_ctrl.sv
// Sleep mode controller: clock gating, wake qualification, wake timing
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Sleep entered only on sleep instruction with sleep_allow set; mode select picks state.
// - Mode 000 stops only CPU and flash clocks; everything else runs.
// - Idle wakes on external and internal peripheral interrupts; comparator may be off.
// - Mode 001 stops I/O, CPU, flash clocks; converter runs, timer only if async.
// - Entering noise reduction with converter enabled starts a conversion automatically.
// - Noise reduction wakes only on converter, reset, watchdog, address match, timer, nonvolatile ready, level, pin-change sources.
// - Mode 010 stops main oscillator and all clocks; only async logic works.
// - Power-down wakes only on reset, watchdog, address match, level, pin change.
// - Async timer oscillator, and in sleep modes other than idle its clock and wake, only when timer is asynchronous.
// - Outside idle, external pins wake only through level interrupts.
// - Brownout switch-off honoured only in power-down, save, standby, extended standby.
// - Interrupt wake halts four cycles after start-up, then runs the handler.
// - Sleep leaves register file and data memory contents unchanged.
// - Reset during sleep wakes and restarts from the reset vector.
// - Brownout detector off right after sleep entry, back on at every wake.
// - Wake delay extended to 60 us after sleeping with brownout detector off.
// - Brownout-sleep-off bit resets to 0; writing 1 turns detector off in sleep.
// - Brownout-sleep-off changes only through timed unlock sequence; other writes ignored.
// - Level wake dropped before start-up end still wakes but raises no interrupt.
// - Power-down wake delay equals clock-source reset time-out period.
// - 011 power-save, 110 standby, 111 extended standby; 100, 101 reserved.
// - Standby and extended standby keep oscillator running, wake in six cycles.
module smc_sleep_ctrl
    import smc_pkg::*;
#(
    parameter int BOD_WAKE = BOD_WAKE_CYCLES
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic sleep_allow, // Sleep allowed by software
    input wire logic [2:0] sleep_mode_select, // Sleep mode code
    input wire logic sleep_instr, // Core executes sleep, pulse
    input wire logic brownout_sleep_off_unlock, // Timed sequence unlock write, pulse
    input wire logic brownout_sleep_off_write, // Brownout-sleep-off write, pulse
    input wire logic brownout_sleep_off_wdata, // Brownout-sleep-off write data
    input wire logic conv_enabled, // Converter enabled
    input wire logic async_timer_async, // Async timer on its own clock
    input wire logic comparator_power_off, // Comparator power-off bit
    input wire logic [CNT_W-1:0] reset_timeout, // Start-up cycles of clock source
    input wire logic rst_req, // Any reset source, level
    input wire logic irq_conv_done, // Converter complete interrupt
    input wire logic irq_wdt, // Watchdog interrupt
    input wire logic irq_twi_match, // Two-wire address match
    input wire logic irq_async_timer, // Async timer interrupt
    input wire logic irq_nvm_ready, // Self-program or nonvolatile ready
    input wire logic irq_ext_level, // External pin level interrupt
    input wire logic irq_ext_edge, // External pin edge interrupt
    input wire logic irq_pin_change, // Pin-change interrupt
    input wire logic irq_periph, // Other peripheral interrupts
    output logic cpu_clk_en, // CPU clock domain running
    output logic flash_clk_en, // Flash clock domain running
    output logic io_clk_en, // I/O clock domain running
    output logic conv_clk_en, // Converter clock domain running
    output logic async_clk_en, // Async timer clock running
    output logic main_osc_en, // Main oscillator enabled
    output logic timer_osc_en, // Timer oscillator enabled
    output logic comparator_en, // Comparator powered
    output logic brownout_detector_en, // Brownout detector enabled
    output logic brownout_sleep_off, // Stored brownout-sleep-off bit
    output logic conv_auto_start, // Start conversion, pulse
    output logic core_halt, // Core stalled
    output logic sleeping, // In a sleep state
    output logic irq_take, // Core enters handler, pulse
    output logic reset_vector // Core restarts at reset vector, pulse
);

    // ****************************************
    // Decode
    // ****************************************
    smc_state_type state;
    smc_state_type next_state;
    logic [2:0] mode;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [2:0] unlock_cnt;
    logic bod_off;
    logic edge_latched;
    logic irq_ok;
    logic mode_valid;
    logic enter;
    logic wake;
    logic level_live;
    logic timer_wake;
    logic deep;
    logic [CNT_W-1:0] wake_delay;

    assign mode_valid = (sleep_mode_select != 3'h4) && (sleep_mode_select != 3'h5);
    assign enter = (state == ST_ACTIVE) && sleep_instr && sleep_allow && mode_valid;
    assign deep = (mode == MODE_PDOWN) || (mode == MODE_PSAVE) ||
                  (mode == MODE_STBY) || (mode == MODE_XSTBY);
    assign timer_wake = irq_async_timer && async_timer_async;
    assign level_live = irq_ext_level;

    // Wake qualification per mode
    always_comb begin
        case (mode)
            MODE_IDLE: begin
                wake = irq_conv_done || irq_wdt || irq_twi_match || irq_async_timer ||
                       irq_nvm_ready || irq_ext_level || irq_ext_edge ||
                       irq_pin_change || irq_periph;
            end
            MODE_NOISE: begin
                wake = irq_conv_done || irq_wdt || irq_twi_match || timer_wake ||
                       irq_nvm_ready || level_live || irq_pin_change;
            end
            MODE_PSAVE, MODE_XSTBY: begin
                wake = irq_wdt || irq_twi_match || timer_wake || level_live ||
                       irq_pin_change;
            end
            default: begin
                wake = irq_wdt || irq_twi_match || level_live || irq_pin_change;
            end
        endcase
    end

    // Start-up delay before the halt
    always_comb begin
        case (mode)
            MODE_PDOWN, MODE_PSAVE: wake_delay = reset_timeout;
            MODE_STBY, MODE_XSTBY: wake_delay = STBY_WAKE_CYCLES;
            default: wake_delay = '0;
        endcase
        if (bod_off && (wake_delay < BOD_WAKE[CNT_W-1:0])) begin
            wake_delay = BOD_WAKE[CNT_W-1:0];
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            ST_ACTIVE: begin
                if (enter) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (rst_req) begin
                    next_state = ST_ACTIVE;
                end else if (wake && (wake_delay == '0)) begin
                    next_state = ST_HALT;
                    next_cnt = HALT_CYCLES;
                end else if (wake) begin
                    next_state = ST_START;
                    next_cnt = wake_delay;
                end
            end
            ST_START: begin
                if (rst_req) begin
                    next_state = ST_ACTIVE;
                end else if (cnt <= 16'h0001) begin
                    next_state = ST_HALT;
                    next_cnt = HALT_CYCLES;
                end else begin
                    next_cnt = cnt - 16'h0001;
                end
            end
            ST_HALT: begin
                if (rst_req || (cnt <= 16'h0001)) begin
                    next_state = ST_ACTIVE;
                end else begin
                    next_cnt = cnt - 16'h0001;
                end
            end
            default: next_state = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_ACTIVE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Mode and brownout switch-off captured at entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= MODE_IDLE;
            bod_off <= 1'b0;
        end else if (enter) begin
            mode <= sleep_mode_select;
            bod_off <= brownout_sleep_off &&
                       (sleep_mode_select[1] || sleep_mode_select[2]);
        end else if (state == ST_ACTIVE) begin
            bod_off <= 1'b0;
        end
    end

    // Interrupt bookkeeping; a level must still stand at start-up end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_latched <= 1'b0;
            irq_ok <= 1'b0;
        end else begin
            if (state == ST_SLEEP && wake) begin
                edge_latched <= wake && !(level_live && !rst_req && mode != MODE_IDLE &&
                                !(irq_wdt || irq_twi_match || irq_pin_change ||
                                  irq_conv_done || irq_nvm_ready || timer_wake));
            end
            if (next_state == ST_HALT && state != ST_HALT) begin
                irq_ok <= (state == ST_SLEEP) || edge_latched || level_live;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_take <= 1'b0;
            reset_vector <= 1'b0;
            conv_auto_start <= 1'b0;
        end else begin
            irq_take <= (state == ST_HALT) && (cnt <= 16'h0001) && !rst_req && irq_ok;
            reset_vector <= (state != ST_ACTIVE) && rst_req;
            conv_auto_start <= enter && (sleep_mode_select == MODE_NOISE) && conv_enabled;
        end
    end

    // ****************************************
    // Brownout-sleep-off bit and unlock
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_cnt <= '0;
            brownout_sleep_off <= BROWNOUT_SLEEP_OFF_RESET;
        end else begin
            if (brownout_sleep_off_unlock) begin
                unlock_cnt <= UNLOCK_WINDOW;
            end else if (unlock_cnt != '0) begin
                unlock_cnt <= unlock_cnt - 3'h1;
            end
            if (brownout_sleep_off_write && (unlock_cnt != '0) && !brownout_sleep_off_unlock) begin
                brownout_sleep_off <= brownout_sleep_off_wdata;
            end
        end
    end

    // ****************************************
    // Clock domain enables
    // ****************************************
    always_comb begin
        cpu_clk_en = (state == ST_ACTIVE) || (state == ST_HALT);
        flash_clk_en = cpu_clk_en;
        io_clk_en = 1'b1;
        conv_clk_en = 1'b1;
        async_clk_en = 1'b1;
        main_osc_en = 1'b1;
        timer_osc_en = async_timer_async;
        if (state == ST_SLEEP) begin
            case (mode)
                MODE_IDLE: begin
                    timer_osc_en = async_timer_async;
                end
                MODE_NOISE: begin
                    io_clk_en = 1'b0;
                    async_clk_en = async_timer_async;
                end
                MODE_STBY, MODE_PDOWN: begin
                    io_clk_en = 1'b0;
                    conv_clk_en = 1'b0;
                    async_clk_en = 1'b0;
                    timer_osc_en = 1'b0;
                    main_osc_en = (mode == MODE_STBY);
                end
                default: begin
                    io_clk_en = 1'b0;
                    conv_clk_en = 1'b0;
                    async_clk_en = async_timer_async;
                    main_osc_en = (mode == MODE_XSTBY);
                end
            endcase
        end
    end

    assign comparator_en = !comparator_power_off && !(state == ST_SLEEP && deep);
    assign brownout_detector_en = !((state == ST_SLEEP) && bod_off);
    assign core_halt = (state != ST_ACTIVE);
    assign sleeping = (state == ST_SLEEP);

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_start6;
        (state == ST_START) [*6] ##1 (state == ST_HALT);
    endsequence
    sequence s_halt4;
        (state == ST_HALT) [*4] ##1 (state == ST_ACTIVE);
    endsequence

    property p_no_allow;
        @(posedge clk) disable iff (!rst_n)
        (state == ST_ACTIVE && sleep_instr && !sleep_allow) |=> !sleeping && cpu_clk_en;
    endproperty
    a_no_allow: assert property (p_no_allow) else $error("sleep without allow");

    property p_enter;
        @(posedge clk) disable iff (!rst_n)
        (state == ST_ACTIVE && sleep_instr && sleep_allow && mode_valid) |=>
            sleeping && (mode == $past(sleep_mode_select));
    endproperty
    a_enter: assert property (p_enter) else $error("sleep not entered");

    property p_idle_clk;
        @(posedge clk) disable iff (!rst_n)
        (sleeping && mode == MODE_IDLE) |-> !cpu_clk_en && io_clk_en && conv_clk_en;
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("idle clocks wrong");

    property p_noise_clk;
        @(posedge clk) disable iff (!rst_n)
        (sleeping && mode == MODE_NOISE) |-> !io_clk_en && conv_clk_en &&
            (async_clk_en == async_timer_async);
    endproperty
    a_noise_clk: assert property (p_noise_clk) else $error("noise clocks wrong");

    property p_pdown_clk;
        @(posedge clk) disable iff (!rst_n)
        (sleeping && mode == MODE_PDOWN) |-> !main_osc_en && !async_clk_en && !conv_clk_en;
    endproperty
    a_pdown_clk: assert property (p_pdown_clk) else $error("power-down clocks");

    property p_conv;
        @(posedge clk) disable iff (!rst_n)
        (enter && sleep_mode_select == MODE_NOISE && conv_enabled) |=> conv_auto_start;
    endproperty
    a_conv: assert property (p_conv) else $error("no auto conversion");

    // Reset request aborts the wake sequence
    property p_stby6;
        @(posedge clk) disable iff (!rst_n || rst_req)
        (sleeping && mode == MODE_STBY && wake && !bod_off) |=> s_start6;
    endproperty
    a_stby6: assert property (p_stby6) else $error("standby wake not six");

    property p_halt_len;
        @(posedge clk) disable iff (!rst_n || rst_req)
        (next_state == ST_HALT && state != ST_HALT) |=> s_halt4;
    endproperty
    a_halt_len: assert property (p_halt_len) else $error("halt not four cycles");

    property p_reset;
        @(posedge clk) disable iff (!rst_n)
        (sleeping && rst_req) |=> reset_vector && !sleeping && !irq_take;
    endproperty
    a_reset: assert property (p_reset) else $error("reset not honoured");

    property p_bod;
        @(posedge clk) disable iff (!rst_n)
        $fell(sleeping) |-> brownout_detector_en ##0
            ($past(!brownout_detector_en) == $past(bod_off));
    endproperty
    a_bod: assert property (p_bod) else $error("detector not restored");

    property p_bod_modes;
        @(posedge clk) disable iff (!rst_n)
        (sleeping && (mode == MODE_IDLE || mode == MODE_NOISE)) |-> brownout_detector_en;
    endproperty
    a_bod_modes: assert property (p_bod_modes) else $error("detector off in light sleep");

    property p_brownout_sleep_off_lock;
        @(posedge clk) disable iff (!rst_n)
        (brownout_sleep_off_write && unlock_cnt == 3'h0) |=> $stable(brownout_sleep_off);
    endproperty
    a_brownout_sleep_off_lock: assert property (p_brownout_sleep_off_lock) else $error("unlocked write taken");

    property p_edge;
        @(posedge clk) disable iff (!rst_n)
        (sleeping && mode != MODE_IDLE && irq_ext_edge && !rst_req && !irq_ext_level &&
         !irq_wdt && !irq_twi_match && !irq_pin_change && !irq_conv_done &&
         !irq_nvm_ready && !irq_async_timer) |=> sleeping;
    endproperty
    a_edge: assert property (p_edge) else $error("edge woke deep sleep");

endmodule // smc_sleep_ctrl
`default_nettype wire
